// ### bench/adcsgs_chk.sv
// Purpose: port checks for the converter scan and status control
// Assumes: pclk 100 MHz, presetn asynchronous active low
// Notes:   sees only the top module ports, attached by bind
`timescale 1ns/1ps
module adcsgs_chk
  import adcsgs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic [1:0] gain_code,
  input wire logic counter0_clk_tick
);
  // -------------------------------------------------------------
  // properties, one clock domain
  // -------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus answer: one wait state, one-cycle pready
  a_ready_one: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not in second access cycle");
  // unmapped places refuse and read zero
  a_err_map: assert property (pready && paddr[11:5] != 7'h00
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_none: assert property (pready && paddr[11:5] == 7'h00
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_rdata_high: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_gain_copy: assert property (
    pready && pwrite && paddr == 12'h00C
    |-> ##2 gain_code == $past(pwdata[1:0], 2))
    else $error("gain code not taken from write");
  a_start_one: assert property (
    conv_start |=> !conv_start [*8])
    else $error("conversion start too close");
  a_chan_hold: assert property (
    conv_start |=> $stable(conv_channel) [*8])
    else $error("channel moved during conversion");
  a_tick_gap: assert property (
    counter0_clk_tick |=> !counter0_clk_tick [*8])
    else $error("counter 0 tick faster than 10 MHz");
endmodule : adcsgs_chk

bind adcsgs_top adcsgs_chk adcsgs_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_start(conv_start), .conv_channel(conv_channel),
  .gain_code(gain_code), .counter0_clk_tick(counter0_clk_tick));

// ### bench/adcsgs_top_bench.sv
// Purpose: self-checking bench for the converter control block
// Assumes: APB master with one idle cycle between transfers
// Notes:   read expectations queue up and a monitor checks them
`timescale 1ns/1ps
module adcsgs_top_bench;
  import adcsgs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [APB_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] smp;
  logic [2:0] ev;
  logic cst, c0t, c1t, irq, xen, c0o;
  logic [3:0] chan, lo, hi, ptr;
  logic [1:0] gain, g;
  logic [32:0] q_e[$], q_m[$];
  int n_errors, checked, k, n;

  adcsgs_top adcsgs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_sample_data(smp), .counter0_output(c0o),
    .external_trigger_input(1'b0), .counter1_external_clock(1'b0),
    .single_ended_strap(1'b1), .sample_buffer_pop(1'b0),
    .timer_event(ev[1]), .digital_event(ev[0]), .transfer_event(ev[2]),
    .conv_start(cst), .conv_channel(chan), .gain_code(gain),
    .transfer_enable(xen), .counter0_clk_tick(c0t),
    .counter1_clk_tick(c1t), .irq_request(irq));

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task end_sim;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task chk_bus(input logic [32:0] e, input logic [32:0] m,
               input logic [32:0] s);
    checked++;
    if ((s & m) !== (e & m)) begin
      n_errors++;
      $display("ERROR bus exp %h seen %h", e & m, s & m);
    end
  endtask : chk_bus

  task chk_pin(input string nm, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s exp %b seen %b", nm, e, s);
    end
  endtask : chk_pin

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [32:0] e, input logic [32:0] m);
    int t;
    q_e.push_back(e);
    q_m.push_back(m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("ERROR pready exp 1 seen %b", pready);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, {7'h00, i, 2'h0}, {24'h00_0000, d}, '0, '0);
  endtask : wr

  task rdx(input logic [2:0] i, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, {7'h00, i, 2'h0}, '0, {25'h000_0000, e}, {25'h100_0000, m});
  endtask : rdx

  // start by command or counter 0 edge, see busy, then poll busy low
  task conv(input logic hw);
    if (hw) begin
      c0o <= 1'b1;
      @(posedge pclk);
      c0o <= 1'b0;
    end else begin
      wr(IDX_RESULT_LOW, 8'h80);
    end
    rdx(IDX_GAIN_STATUS, 8'h80, 8'h80);
    n = 0;
    do begin
      rdx(IDX_GAIN_STATUS, 8'h00, 8'h00);
      n++;
    end while (rd[7] !== 1'b0 && n < 3000);
    if (rd[7] !== 1'b0) begin
      n_errors++;
      $display("ERROR conversion_busy exp 0 seen %b", rd[7]);
    end
  endtask : conv

  // bus results are compared in order of request
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (q_e.size() == 0) begin
        n_errors++;
        $display("ERROR bus exp none seen %h", prdata);
      end else chk_bus(q_e.pop_front(), q_m.pop_front(), {pslverr, prdata});
    end
  end

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #900us;
    n_errors++;
    end_sim;
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; smp = '0; ev = '0; c0o = 1'b0;
    n_errors = 0; checked = 0;
    void'($urandom(32'h79c1_222d));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdx(IDX_SCAN_RANGE, 8'h00, 8'hFF);
    rdx(IDX_GAIN_STATUS, 8'h40, 8'hFF);
    apb(1'b0, 12'h100, '0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    $display("test 1 done");
    lo = 4'($urandom % 8);
    hi = lo + 4'($urandom % 8);
    g = 2'($urandom);
    wr(IDX_SCAN_RANGE, {hi, lo});
    rdx(IDX_SCAN_RANGE, {hi, lo}, 8'hFF);
    rdx(IDX_GAIN_STATUS, 8'h60, 8'hF8);
    wr(IDX_GAIN_STATUS, {6'h00, g});
    repeat (900) @(posedge pclk);
    rdx(IDX_GAIN_STATUS, {6'h18, g}, 8'hFF);
    chk_pin("gain_code", 1'b1, gain === g);
    repeat (120) @(posedge pclk);
    rdx(IDX_GAIN_STATUS, {6'h10, g}, 8'hFF);
    $display("test 2 done");
    rdx(IDX_PENDING, {4'h0, lo}, 8'h0F);
    ptr = lo;
    for (k = 0; k < hi - lo + 2; k++) begin
      smp <= 16'($urandom);
      conv(1'b0);
      rdx(IDX_RESULT_LOW, smp[7:0], 8'hFF);
      rdx(IDX_RESULT_HIGH, smp[15:8], 8'hFF);
      ptr = (ptr == hi) ? lo : ptr + 4'h1;
      rdx(IDX_PENDING, {4'h0, ptr}, 8'h0F);
    end
    rdx(IDX_DEPTH, 8'(hi - lo + 2), 8'hFF);
    wr(IDX_RESULT_LOW, 8'h10);
    rdx(IDX_DEPTH, 8'h00, 8'hFF);
    $display("test 3 done");
    wr(IDX_GAIN_STATUS, {5'h00, 1'b1, g});
    repeat (1010) @(posedge pclk);
    conv(1'b0);
    rdx(IDX_DEPTH, 8'(hi - lo + 1), 8'hFF);
    rdx(IDX_PENDING, {4'h0, lo}, 8'h0F);
    wr(IDX_CONTROL, 8'h01);
    wr(IDX_RESULT_LOW, 8'h90);
    rdx(IDX_GAIN_STATUS, 8'h00, 8'h80);
    rdx(IDX_DEPTH, 8'h00, 8'hFF);
    conv(1'b1);
    rdx(IDX_PENDING, {4'h1, lo}, 8'hFF);
    chk_pin("irq_request", 1'b1, irq);
    wr(IDX_RESULT_LOW, 8'h01);
    $display("test 4 done");
    for (k = 1; k < 4; k++) begin
      wr(IDX_CONTROL, 8'(1 << k));
      rdx(IDX_CONTROL, 8'(1 << k), 8'hFF);
      chk_pin("transfer_enable", k == 3, xen);
      ev <= 3'(1 << (k - 1));
      @(posedge pclk);
      ev <= '0;
      repeat (3) @(posedge pclk);
      chk_pin("irq_request", 1'b1, irq);
      rdx(IDX_PENDING, 8'(16 << k), 8'hF0);
      wr(IDX_RESULT_LOW, 8'(1 << k));
      rdx(IDX_PENDING, 8'h00, 8'hF0);
      chk_pin("irq_request", 1'b0, irq);
    end
    wr(IDX_PENDING, 8'h00);
    rdx(IDX_GAIN_STATUS, 8'h10, 8'h10);
    repeat (3000) @(posedge pclk);
    rdx(IDX_GAIN_STATUS, 8'h00, 8'h10);
    wr(IDX_CONTROL, 8'h60);
    n = 0;
    k = 0;
    repeat (1000) begin
      @(posedge pclk);
      n += c0t;
      k += c1t;
    end
    chk_pin("counter0_clk_tick", 1'b1, n == 10);
    chk_pin("counter1_clk_tick", 1'b1, k == 1);
    wr(IDX_CONTROL, 8'h00);
    ev <= 3'h7;
    @(posedge pclk);
    ev <= '0;
    rdx(IDX_PENDING, 8'h00, 8'hF0);
    $display("test 5 done");
    end_sim;
  end
endmodule : adcsgs_top_bench

// ### hw/adcsgs_hold_timer.sv
// Purpose: one-shot flag that stays high a fixed number of cycles
// Assumes: start is a single-cycle pulse on the same clock
// Notes:   a new start reloads the count, so only the last one matters
`timescale 1ns/1ps
module adcsgs_hold_timer #(
  parameter int CYCLES = 1000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic active
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] next_remain;

  // -----------------------------------------------------------------------
  // down counter
  // -----------------------------------------------------------------------
  // reload wins over counting so back-to-back starts extend the window
  assign next_remain = start ? LOAD :
                       (remain != '0) ? remain - ONE : remain;

  // flag high for exactly CYCLES edges after the start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= '0;
      active <= 1'b0;
    end else begin
      remain <= next_remain;
      active <= (next_remain != '0);
    end
  end

endmodule : adcsgs_hold_timer

// ### hw/adcsgs_pkg.sv
// Purpose: shared constants for the converter scan, gain and status control
// Assumes: 100 MHz pclk, byte registers placed one per aligned APB word
// Notes:   register index times four gives the APB byte address
package adcsgs_pkg;

  // ---------------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam logic [2:0] IDX_RESULT_LOW = 3'h0;
  localparam logic [2:0] IDX_RESULT_HIGH = 3'h1;
  localparam logic [2:0] IDX_SCAN_RANGE = 3'h2;
  localparam logic [2:0] IDX_GAIN_STATUS = 3'h3;
  localparam logic [2:0] IDX_CONTROL = 3'h4;
  localparam logic [2:0] IDX_THRESHOLD = 3'h5;
  localparam logic [2:0] IDX_DEPTH = 3'h6;
  localparam logic [2:0] IDX_PENDING = 3'h7;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int CMD_START_BIT = 7;
  localparam int CMD_FIFO_RST_BIT = 4;
  localparam int REQ_TRANSFER = 3;
  localparam int REQ_TIMER = 2;
  localparam int REQ_DIGITAL = 1;
  localparam int REQ_ANALOG = 0;
  localparam int CTL_C1_SOURCE = 7;
  localparam int CTL_C1_RATE = 6;
  localparam int CTL_C0_RATE = 5;
  localparam int CTL_TRIG_SEL = 4;
  localparam int GS_SCAN_BIT = 2;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_SCAN_RANGE = 8'h00;
  localparam logic [2:0] RST_GAIN_SCAN = 3'h0;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [5:0] RST_THRESHOLD = 6'h00;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  // ---------------------------------------------------------------------
  // sample buffer bookkeeping
  // ---------------------------------------------------------------------
  localparam logic [5:0] FIFO_DEPTH = 6'h30;
  localparam logic [5:0] THRESH_MIN = 6'h01;
  localparam logic [5:0] THRESH_MAX = 6'h30;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int DAC_BUSY_TIME_NS = 30000;
  localparam int CONV_TIME_NS = 5000;
  localparam int SETTLE_CYCLES =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DAC_BUSY_CYCLES =
    (DAC_BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 10;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST =
    CONV_CNT_W'(CONV_CYCLES - 1);
  // 100 MHz divided by ten per stage: 10 MHz, 1 MHz, 100 kHz
  localparam logic [3:0] DECADE_LAST = 4'h9;

  // conversion sequencer states
  typedef enum logic [0:0] {
    ADCSGS_IDLE = 1'b0,
    ADCSGS_CONVERT = 1'b1
  } adcsgs_state_e;

endpackage : adcsgs_pkg

// ### hw/adcsgs_top.sv
// Purpose: register control of a 16-channel converter, scan and status
// Assumes: APB slave, one byte register per aligned word, 100 MHz pclk
// Notes:   converter analog path, sample storage and counters live outside
//
// Contract
// - result is a 16-bit word, low byte at index 0, high at 1
// - range register holds upper channel bits 7-4, lower bits 3-0
// - writing the range register loads the pointer with lower
// - each conversion advances the pointer, wrapping upper to lower
// - range register reads back the byte last written
// - range or gain write raises settling flag for the interval
// - scan mode converts lower through upper, busy whole scan
// - single mode converts current channel once, then advances
// - two-bit gain code in bits 1-0 selects gain 1, 2, 4, 8
// - status byte: busy, mode, settling, output busy, overflow
// - mode indicator reads 1 single-ended, 0 differential
// - output converter busy held about 30 us after data write
// - storing into a full buffer sets sticky overflow, refuses
// - control bits 3-0 enable transfer, timer, digital, analog
// - no request source exists for analog output activity
// - all enabled sources share one request line
// - command bits are independent one-shot triggers
// - buffer reset sets stored sample count to zero
// - index 7 reads pending requests in bits 7-4
// - analog request when count reaches clamped threshold 1-48
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module adcsgs_top
  import adcsgs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] conv_sample_data,
  input wire logic counter0_output,
  input wire logic external_trigger_input,
  input wire logic counter1_external_clock,
  input wire logic single_ended_strap,
  input wire logic sample_buffer_pop,
  input wire logic timer_event,
  input wire logic digital_event,
  input wire logic transfer_event,
  output logic conv_start,
  output logic [3:0] conv_channel,
  output logic [1:0] gain_code,
  output logic transfer_enable,
  output logic counter0_clk_tick,
  output logic counter1_clk_tick,
  output logic irq_request
);

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  adcsgs_state_e conv_state;
  adcsgs_state_e next_conv_state;
  logic [CONV_CNT_W-1:0] conv_count;
  logic [7:0] scan_range;
  logic [2:0] gain_scan;
  logic [7:0] control;
  logic [5:0] threshold;
  logic [15:0] result_word;
  logic [5:0] depth;
  logic sample_overflow;
  logic [3:0] pending;
  logic [3:0] chan_ptr;
  logic settle_active;
  logic dac_active;
  logic ext_sync1;
  logic ext_sync2;
  logic ext_prev;
  logic counter1_external_clock_sync1;
  logic counter1_external_clock_sync2;
  logic counter1_external_clock_prev;
  logic mode_sync1;
  logic single_ended_indicator;
  logic c0_prev;
  logic [3:0] div_a;
  logic [3:0] div_b;
  logic [3:0] div_c;

  // -----------------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------------
  wire access_done = psel & penable & pready;
  wire [2:0] reg_idx = paddr[4:2];
  wire addr_ok = (paddr[APB_ADDR_W-1:5] == '0) & (paddr[1:0] == 2'b00);
  wire wr_en = access_done & pwrite & addr_ok;
  wire [7:0] wbyte = pwdata[7:0];
  wire wr_cmd = wr_en & (reg_idx == IDX_RESULT_LOW);
  wire wr_range = wr_en & (reg_idx == IDX_SCAN_RANGE);
  wire wr_gain = wr_en & (reg_idx == IDX_GAIN_STATUS);
  wire wr_ctl = wr_en & (reg_idx == IDX_CONTROL);
  wire wr_thr = wr_en & (reg_idx == IDX_THRESHOLD);
  // writing index 7 (IDX_PENDING) fires the output converter update
  wire wr_dac = wr_en & (reg_idx == IDX_PENDING);

  wire [3:0] upper_scan_channel = scan_range[7:4];
  wire [3:0] lower_scan_channel = scan_range[3:0];
  wire scan_enable = gain_scan[GS_SCAN_BIT];
  wire analog_irq_enable = control[REQ_ANALOG];
  wire trigger_select = control[CTL_TRIG_SEL];

  // -----------------------------------------------------------------------
  // command strobes
  // -----------------------------------------------------------------------
  // independent one-shots
  wire [3:0] request_clear = wr_cmd ? wbyte[3:0] : 4'h0;
  wire sample_buffer_reset_cmd = wr_cmd & wbyte[CMD_FIFO_RST_BIT];
  wire start_conversion_cmd = wr_cmd & wbyte[CMD_START_BIT]
                              & ~analog_irq_enable;

  wire c0_rise = counter0_output & ~c0_prev;
  wire ext_rise = ext_sync2 & ~ext_prev;
  wire hw_trigger = analog_irq_enable & (trigger_select ? ext_rise : c0_rise);

  // triggers that land while busy are dropped, not queued
  wire conv_idle = (conv_state == ADCSGS_IDLE);
  wire trigger = (start_conversion_cmd | hw_trigger) & conv_idle;
  wire conv_end = (conv_state == ADCSGS_CONVERT) & (conv_count == CONV_LAST);

  // -----------------------------------------------------------------------
  // channel pointer
  // -----------------------------------------------------------------------
  // >= rather than == keeps a misprogrammed range from running past upper
  wire at_upper = (chan_ptr >= upper_scan_channel);
  wire [3:0] ptr_advanced = at_upper ? lower_scan_channel : chan_ptr + 4'h1;
  wire scan_more = conv_end & scan_enable & ~at_upper;
  wire [3:0] first_channel = scan_enable ? lower_scan_channel : chan_ptr;
  wire [3:0] next_ptr = wr_range ? wbyte[3:0] :
                        (trigger & scan_enable) ? lower_scan_channel :
                        conv_end ? ptr_advanced : chan_ptr;

  // -----------------------------------------------------------------------
  // sequencer next state
  // -----------------------------------------------------------------------
  always_comb begin
    next_conv_state = conv_state;
    unique case (conv_state)
      ADCSGS_IDLE: begin
        if (trigger) begin
          next_conv_state = ADCSGS_CONVERT;
        end
      end
      ADCSGS_CONVERT: begin
        if (conv_end && !scan_more) begin
          next_conv_state = ADCSGS_IDLE;
        end
      end
    endcase
  end

  wire step_start = trigger | scan_more;

  // -----------------------------------------------------------------------
  // sample count and requests
  // -----------------------------------------------------------------------
  wire buffer_full = (depth == FIFO_DEPTH);
  wire store_ok = conv_end & ~buffer_full & ~sample_overflow;
  wire overflow_hit = conv_end & (buffer_full | sample_overflow);
  wire pop_ok = sample_buffer_pop & (depth != 6'h00);
  wire [5:0] next_depth = depth + {5'h00, store_ok} - {5'h00, pop_ok};
  wire [5:0] thresh_eff = (threshold == 6'h00) ? THRESH_MIN :
                          (threshold > THRESH_MAX) ? THRESH_MAX : threshold;
  wire analog_hit = store_ok & (next_depth == thresh_eff);
  // only four sources, none for output activity
  wire [3:0] request_set = {transfer_event, timer_event,
                            digital_event, analog_hit} & control[3:0];
  // set beats clear when both land in one cycle
  wire [3:0] next_pending = (pending & ~request_clear) | request_set;

  // -----------------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------------
  // status layout
  wire [7:0] status_byte = {~conv_idle, single_ended_indicator,
                            settle_active, dac_active, sample_overflow,
                            gain_scan};
  wire [7:0] pending_byte = {pending, chan_ptr};
  wire [7:0] rd_byte =
    !addr_ok ? 8'h00 :
    (reg_idx == IDX_RESULT_LOW) ? result_word[7:0] :
    (reg_idx == IDX_RESULT_HIGH) ? result_word[15:8] :
    (reg_idx == IDX_SCAN_RANGE) ? scan_range :
    (reg_idx == IDX_GAIN_STATUS) ? status_byte :
    (reg_idx == IDX_CONTROL) ? control :
    (reg_idx == IDX_THRESHOLD) ? {2'b00, threshold} :
    (reg_idx == IDX_DEPTH) ? {2'b00, depth} : pending_byte;

  // -----------------------------------------------------------------------
  // apb slave, one wait state
  // -----------------------------------------------------------------------
  // ready is registered so every output leaves a flop; costs one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // -----------------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_range <= RST_SCAN_RANGE;
      gain_scan <= RST_GAIN_SCAN;
      control <= RST_CONTROL;
      threshold <= RST_THRESHOLD;
    end else begin
      if (wr_range) begin
        scan_range <= wbyte;
      end
      if (wr_gain) begin
        gain_scan <= wbyte[2:0];
      end
      if (wr_ctl) begin
        control <= wbyte;
      end
      if (wr_thr) begin
        threshold <= wbyte[5:0];
      end
    end
  end

  // -----------------------------------------------------------------------
  // sequencer and pointer
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_state <= ADCSGS_IDLE;
      conv_count <= '0;
      chan_ptr <= 4'h0;
      conv_start <= 1'b0;
      conv_channel <= 4'h0;
      result_word <= RST_RESULT;
    end else begin
      conv_state <= next_conv_state;
      conv_count <= step_start ? '0 : conv_count + CONV_CNT_W'(1);
      chan_ptr <= next_ptr;
      conv_start <= step_start;
      if (trigger) begin
        conv_channel <= first_channel;
      end else if (scan_more) begin
        conv_channel <= ptr_advanced;
      end
      if (conv_end) begin
        result_word <= conv_sample_data;
      end
    end
  end

  // -----------------------------------------------------------------------
  // sample count, overflow and requests
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth <= 6'h00;
      sample_overflow <= 1'b0;
      pending <= 4'h0;
      irq_request <= 1'b0;
    end else begin
      depth <= sample_buffer_reset_cmd ? 6'h00 : next_depth;
      sample_overflow <= (sample_overflow & ~sample_buffer_reset_cmd)
                         | overflow_hit;
      pending <= next_pending;
      irq_request <= |(pending & control[3:0]);
    end
  end

  // -----------------------------------------------------------------------
  // pin synchronisers and edge history
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
      counter1_external_clock_sync1 <= 1'b0;
      counter1_external_clock_sync2 <= 1'b0;
      counter1_external_clock_prev <= 1'b0;
      mode_sync1 <= 1'b0;
      single_ended_indicator <= 1'b0;
      c0_prev <= 1'b0;
    end else begin
      ext_sync1 <= external_trigger_input;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_sync2;
      counter1_external_clock_sync1 <= counter1_external_clock;
      counter1_external_clock_sync2 <= counter1_external_clock_sync1;
      counter1_external_clock_prev <= counter1_external_clock_sync2;
      mode_sync1 <= single_ended_strap;
      single_ended_indicator <= mode_sync1;
      c0_prev <= counter0_output;
    end
  end

  // -----------------------------------------------------------------------
  // timebase and counter clock selection
  // -----------------------------------------------------------------------
  wire tick_10m = (div_a == DECADE_LAST);
  wire tick_1m = tick_10m & (div_b == DECADE_LAST);
  wire tick_100k = tick_1m & (div_c == DECADE_LAST);
  wire counter1_external_clock_rise = counter1_external_clock_sync2 & ~counter1_external_clock_prev;
  wire c0_tick = control[CTL_C0_RATE] ? tick_1m : tick_10m;
  wire c1_internal = control[CTL_C1_RATE] ? tick_100k : tick_10m;
  wire c1_tick = control[CTL_C1_SOURCE] ? counter1_external_clock_rise : c1_internal;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_a <= 4'h0;
      div_b <= 4'h0;
      div_c <= 4'h0;
      counter0_clk_tick <= 1'b0;
      counter1_clk_tick <= 1'b0;
      gain_code <= 2'b00;
      transfer_enable <= 1'b0;
    end else begin
      div_a <= tick_10m ? 4'h0 : div_a + 4'h1;
      if (tick_10m) begin
        div_b <= (div_b == DECADE_LAST) ? 4'h0 : div_b + 4'h1;
      end
      if (tick_1m) begin
        div_c <= (div_c == DECADE_LAST) ? 4'h0 : div_c + 4'h1;
      end
      counter0_clk_tick <= c0_tick;
      counter1_clk_tick <= c1_tick;
      gain_code <= gain_scan[1:0];
      transfer_enable <= control[REQ_TRANSFER];
    end
  end

  // -----------------------------------------------------------------------
  // settling and output converter busy windows
  // -----------------------------------------------------------------------
  // settling window
  adcsgs_hold_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .start(wr_range | wr_gain),
    .active(settle_active)
  );

  adcsgs_hold_timer #(
    .CYCLES(DAC_BUSY_CYCLES)
  ) u_dac_busy (
    .pclk(pclk),
    .presetn(presetn),
    .start(wr_dac),
    .active(dac_active)
  );

endmodule : adcsgs_top
